// ### src/ewsc_regs.vh
// Register offsets, field positions, reset values and mode encodings for the wait-state controller.
`ifndef EWSC_REGS_VH
`define EWSC_REGS_VH

// ----------------------------------------------------------------------------
// Register map (byte offsets on the Wishbone bus)
// ----------------------------------------------------------------------------
`define EWSC_WAIT_CONTROL_REG_ADDR 4'h0
`define EWSC_STATUS_REG_ADDR 4'h4
`define EWSC_ADDR_W 4

// ----------------------------------------------------------------------------
// Field layout of the wait control register
// ----------------------------------------------------------------------------
`define EWSC_WAIT_COUNT_LO 0
`define EWSC_WAIT_COUNT_HI 1
`define EWSC_WAIT_MODE_SELECT_LO 2
`define EWSC_WAIT_MODE_SELECT_HI 3
`define EWSC_WCR_RESET 8'hF3
`define EWSC_WCR_RSVD 4'hF

// ----------------------------------------------------------------------------
// Wait mode encodings
// ----------------------------------------------------------------------------
`define EWSC_MODE_PROG 2'h0
`define EWSC_MODE_NOWAIT 2'h1
`define EWSC_MODE_PIN 2'h2
`define EWSC_MODE_AUTO 2'h3

`endif

// ### src/ewsc_wait_sync.v
// Two-flop synchroniser for the asynchronous wait request pin.
`timescale 1ns/1ps
module ewsc_wait_sync (
  input wire mclk_in,
  input wire reset_n_in,
  input wire async_in,
  output reg sync_out
);
  reg meta_r;

  // Resets high so the idle pin means no wait request.
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ### src/ewsc_wait_ctrl.v
// External bus wait-state controller with its Wishbone register slave.
`timescale 1ns/1ps
`include "ewsc_regs.vh"
module ewsc_wait_ctrl (
  input wire mclk_in,
  input wire reset_n_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [3:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  output reg wb_err_out,
  input wire bus_start_in,
  input wire bus_offchip_in,
  output reg second_bus_state_out,
  output reg inserted_wait_state_out,
  output reg third_bus_state_out,
  output reg bus_busy_out,
  input wire port1_pin4_in,
  output reg port1_pin4_is_wait_out
);

  // --------------------------------------------------------------------------
  // State encodings
  // --------------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_T2 = 4'h2;
  localparam [3:0] ST_TW = 4'h4;
  localparam [3:0] ST_T3 = 4'h8;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [1:0] wmode_r;
  reg [1:0] wcount_r;
  reg [1:0] cyc_mode_r;
  reg [1:0] cyc_mode_nxt;
  reg [1:0] cyc_left_r;
  reg [1:0] cyc_left_nxt;
  reg cyc_ext_r;
  reg cyc_ext_nxt;
  reg [7:0] cycles_r;
  wire wait_pin_s;
  wire pin_low;
  wire [7:0] wcr_val;

  // --------------------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------------------
  ewsc_wait_sync u_sync (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .async_in(port1_pin4_in),
    .sync_out(wait_pin_s)
  );

  assign pin_low = ~wait_pin_s;
  assign wcr_val = {`EWSC_WCR_RSVD, wmode_r, wcount_r};

  // --------------------------------------------------------------------------
  // Wishbone register slave: one-cycle ack, err on unmapped addresses
  // --------------------------------------------------------------------------
  wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
  wire hit_wcr = (wb_adr_in == `EWSC_WAIT_CONTROL_REG_ADDR);
  wire hit_sts = (wb_adr_in == `EWSC_STATUS_REG_ADDR);

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wmode_r <= 2'h0;
      wcount_r <= 2'h3;
      wb_ack_out <= 1'b0;
      wb_err_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_req & (hit_wcr | hit_sts);
      wb_err_out <= wb_req & ~(hit_wcr | hit_sts);
      wb_dat_out <= 32'h0;
      if (wb_req & hit_wcr) begin
        if (wb_we_in & wb_sel_in[0]) begin
          wmode_r <= wb_dat_in[`EWSC_WAIT_MODE_SELECT_HI:
                               `EWSC_WAIT_MODE_SELECT_LO];
          wcount_r <= wb_dat_in[`EWSC_WAIT_COUNT_HI:`EWSC_WAIT_COUNT_LO];
        end
        wb_dat_out <= {24'h0, wcr_val};
      end else if (wb_req & hit_sts) begin
        wb_dat_out <= {16'h0, cycles_r, 4'h0, state_r};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bus state sequencer
  // --------------------------------------------------------------------------
  // The mode and count are latched at T2 entry so a register write during a
  // cycle cannot stretch or cut it short.
  always @* begin
    state_nxt = state_r;
    cyc_mode_nxt = cyc_mode_r;
    cyc_left_nxt = cyc_left_r;
    cyc_ext_nxt = cyc_ext_r;
    case (state_r)
      ST_IDLE: begin
        if (bus_start_in) begin
          state_nxt = ST_T2;
          cyc_mode_nxt = bus_offchip_in ? wmode_r : `EWSC_MODE_NOWAIT;
          cyc_left_nxt = wcount_r;
          cyc_ext_nxt = bus_offchip_in;
        end
      end
      ST_T2: begin
        state_nxt = ST_T3;
        case (cyc_mode_r)
          `EWSC_MODE_PROG: begin
            if (cyc_left_r != 2'h0)
              state_nxt = ST_TW;
          end
          `EWSC_MODE_PIN: begin
            if (cyc_left_r != 2'h0 || pin_low)
              state_nxt = ST_TW;
          end
          `EWSC_MODE_AUTO: begin
            if (pin_low && cyc_left_r != 2'h0)
              state_nxt = ST_TW;
          end
          default: state_nxt = ST_T3;
        endcase
        if (state_nxt == ST_TW && cyc_left_r != 2'h0)
          cyc_left_nxt = cyc_left_r - 2'h1;
      end
      ST_TW: begin
        if (cyc_left_r != 2'h0) begin
          cyc_left_nxt = cyc_left_r - 2'h1;
        end else if (cyc_mode_r == `EWSC_MODE_PIN && pin_low) begin
          state_nxt = ST_TW;
        end else begin
          state_nxt = ST_T3;
        end
      end
      ST_T3: begin
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      cyc_mode_r <= 2'h1;
      cyc_left_r <= 2'h0;
      cyc_ext_r <= 1'b0;
      cycles_r <= 8'h0;
    end else begin
      state_r <= state_nxt;
      cyc_mode_r <= cyc_mode_nxt;
      cyc_left_r <= cyc_left_nxt;
      cyc_ext_r <= cyc_ext_nxt;
      if (state_r == ST_TW)
        cycles_r <= cycles_r + 8'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      second_bus_state_out <= 1'b0;
      inserted_wait_state_out <= 1'b0;
      third_bus_state_out <= 1'b0;
      bus_busy_out <= 1'b0;
      port1_pin4_is_wait_out <= 1'b0;
    end else begin
      second_bus_state_out <= (state_nxt == ST_T2);
      inserted_wait_state_out <= (state_nxt == ST_TW);
      third_bus_state_out <= (state_nxt == ST_T3);
      bus_busy_out <= (state_nxt != ST_IDLE);
      port1_pin4_is_wait_out <= wmode_r[1];
    end
  end

endmodule

// ### test/ewsc_slow_dev.sv
// Slow device whose address decode drives the wait pin.
`timescale 1ns/1ps
module ewsc_slow_dev (
  input wire sel_in,
  output wire wait_n_out);
  assign wait_n_out = ~sel_in;
endmodule

// ### test/ewsc_wait_ctrl_checker.sv
// Port assertions for the wait-state controller.
`timescale 1ns/1ps
module ewsc_wait_ctrl_checker (
  input wire mclk_in,
  input wire reset_n_in,
  input wire wb_we_in,
  input wire [3:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire wb_ack_out,
  input wire bus_start_in,
  input wire bus_offchip_in,
  input wire second_bus_state_out,
  input wire inserted_wait_state_out,
  input wire third_bus_state_out,
  input wire bus_busy_out,
  input wire port1_pin4_is_wait_out);
  // Shadow of mode and count, since only the ports are visible here.
  reg [3:0] cfg_r;
  wire t2 = second_bus_state_out, tw = inserted_wait_state_out;
  wire t3 = third_bus_state_out, st = bus_start_in && !bus_busy_out;
  wire go = st && bus_offchip_in;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  always @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in) cfg_r <= 4'h3;
    else if (wb_ack_out && wb_we_in && wb_adr_in == 4'h0)
      cfg_r <= wb_dat_in[3:0];
  a_t2_follows: assert property (
    st |=> t2) else $error("No T2.");
  a_t2_single: assert property (
    t2 |=> !t2 && (tw || t3)) else $error("Bad state after T2.");
  a_t3_closes: assert property (
    t3 |=> !t3 && !bus_busy_out) else $error("No end after T3.");
  a_onchip_none: assert property (
    st && !bus_offchip_in |=> ##1 t3) else $error("On-chip waited.");
  a_nowait_mode: assert property (
    go && cfg_r[3:2] == 2'h1 |=> ##1 t3) else $error("Mode 01 waited.");
  a_prog_three: assert property (
    go && cfg_r == 4'h3 |=> ##1 tw [*3] ##1 t3) else $error("Not 3 waits.");
  a_zero_count: assert property (
    go && cfg_r[3:2] != 2'h2 && cfg_r[1:0] == 2'h0 |=> ##1 t3)
    else $error("Count 0 waited.");
  a_pin_func: assert property (
    !$past(wb_ack_out) && !$past(wb_ack_out, 2) |->
    port1_pin4_is_wait_out == cfg_r[3]) else $error("Pin function wrong.");
  c_prog: cover property (go && cfg_r == 4'h3);
  c_pin: cover property (tw && cfg_r == 4'h8);
  c_auto: cover property (tw && cfg_r[3:2] == 2'h3);
endmodule
bind ewsc_wait_ctrl ewsc_wait_ctrl_checker chk (.*);

// ### test/tb_ewsc_wait_ctrl.sv
// Random and corner-case bench for the wait-state controller.
`timescale 1ns/1ps
module tb_ewsc_wait_ctrl;
  reg mclk_in = 1'h0, reset_n_in = 1'h0, wb_cyc_in = 1'h0, e, o, s;
  reg wb_stb_in = 1'h0, wb_we_in = 1'h0, bus_start_in = 1'h0;
  reg bus_offchip_in = 1'h0, sel = 1'h0;
  reg [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'hF;
  reg [31:0] wb_dat_in = 32'h0, rd;
  reg [1:0] m, c;
  wire [31:0] wb_dat_out;
  wire wb_ack_out, wb_err_out, second_bus_state_out, inserted_wait_state_out;
  wire third_bus_state_out, bus_busy_out, port1_pin4_in;
  wire port1_pin4_is_wait_out;
  integer failures = 0, n_compared = 0, w, i;
  always #12.5 mclk_in = ~mclk_in;
  ewsc_slow_dev dev (.sel_in(sel), .wait_n_out(port1_pin4_in));
  ewsc_wait_ctrl dut (.*);
  task chk(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) $display("Error %0t got %h exp %h", $time, got, exp);
    failures = failures + (got !== exp);
  endtask
  task wb(input we, input [3:0] a, input [31:0] d);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'h3, we, a, d};
    @(posedge mclk_in);
    while (!wb_ack_out && !wb_err_out) @(posedge mclk_in);
    {rd, e} = {wb_dat_out, wb_err_out};
    {wb_cyc_in, wb_stb_in} <= 2'h0;
    @(posedge mclk_in);
  endtask
  // The pin is released mid-cycle so pin wait mode cannot hang.
  task bus(input o_in);
    integer k;
    {bus_start_in, bus_offchip_in} <= {1'h1, o_in};
    w = 0;
    @(posedge mclk_in);
    bus_start_in <= 1'h0;
    @(posedge mclk_in);
    chk(second_bus_state_out, 1);
    for (k = 1; k < 40 && third_bus_state_out !== 1'h1; k = k + 1) begin
      @(posedge mclk_in);
      w = w + inserted_wait_state_out;
      if (k == 4) sel <= 1'h0;
    end
    chk(third_bus_state_out, 1);
  endtask
  function integer exp_w(input [1:0] md, ct, input o_in, s_in);
    exp_w = o_in && (!md[0] || md == 2'h3 && s_in) ? ct : 0;
  endfunction
  initial begin
    i = $urandom(94);
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'h1;
    repeat (2) @(posedge mclk_in);
    wb(1'h0, 4'h8, 32'h0);
    chk(e, 1);
    wb(1'h0, 4'h0, 32'h0);
    chk(rd, 32'hF3);
    bus(1'h1);
    chk(w, 3);
    wb(1'h0, 4'h4, 32'h0);
    chk(rd, 32'h00000301);
    for (i = 0; i < 30; i = i + 1) begin
      {m, c, o, s} = (i < 4) ? {i[1:0], 4'h3} : $urandom;
      sel <= s;
      wb(1'h1, 4'h0, {28'h0, m, c});
      wb(1'h0, 4'h0, 32'h0);
      chk(rd, {24'h0, 4'hF, m, c});
      chk(port1_pin4_is_wait_out, m[1]);
      bus(o);
      if (m == 2'h2 && s && o) chk(w > c && w < 9, 1);
      else chk(w, exp_w(m, c, o, s));
    end
    tally_and_finish;
  end
  task tally_and_finish;
    $display("Compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    tally_and_finish;
  end
endmodule
